// [pkg/pspc_pkg.sv]
package pspc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_ARCOUNT = 4'h8;
  localparam logic [3:0] OFS_EVENT   = 4'hC;
  // control fields
  localparam int CTRL_OVR_BIT  = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MUTE_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status fields
  localparam int ST_LATCH_BIT = 0;
  localparam int ST_HIZ_BIT   = 1;
  localparam int ST_OC_BIT    = 2;
  localparam int ST_UV_BIT    = 3;
  localparam int ST_TERR_BIT  = 4;
  localparam int ST_TWARN_BIT = 5;
  localparam int ST_MODE_LSB  = 6;
  localparam int ST_RSVD_BIT  = 8;
  localparam int ST_SDPIN_BIT = 9;
  localparam int ST_OTPIN_BIT = 10;
  // sticky event fields, write one to clear
  localparam int EV_OC_BIT = 0;
  localparam int EV_UV_BIT = 1;
  localparam int EV_OT_BIT = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  // autorecovery length in pwm cycles
  localparam int RECOVER_CYCLES = 512;
  // straps: first low, second high selects latching
  localparam logic [1:0] STRAP_LATCH = 2'h1;
  localparam logic       OUT_MODE_BRIDGE_TIED = 1'b0;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_AUTO  = 2'h0,
    MODE_LATCH = 2'h1,
    MODE_OFF   = 2'h2
  } prot_mode_type;

  typedef enum logic [2:0] {
    RCV_IDLE = 3'h1,
    RCV_TRIP = 3'h2,
    RCV_WAIT = 3'h4
  } rcv_state_type;
endpackage : pspc_pkg

// [rtl/pspc_top.sv]
// How it works
// [RQ1] reset low forces both bridges Hi-Z
// [RQ2] controller holds reset low about 1 ms
// [RQ3] release reset only with valid PWM running
// [RQ4] controller never holds PWM high
// [RQ5] reset low before PWM stops at power-down
// [RQ6] shutdown pin low while protection latched
// [RQ7] reset low releases shutdown pin high
// [RQ8] warning pin low above 125 C
// [RQ9] two pins jointly encode chip state
// [RQ10] every error forces output stage Hi-Z
// [RQ11] reset toggle recovers after errors clear
// [RQ12] latch clears on reset fall, run on rise
// [RQ13] reset low mutes switching regardless of errors
// [RQ14] high and low side overcurrent both trip
// [RQ15] gate supply undervoltage locks out operation
// [RQ16] one shared overtemperature detector and warning
// [RQ17] autorecovery: latch clears n/2, resume at n
// [RQ18] recovery counts pwm cycles, one circuit
// [RQ19] latching mode holds Hi-Z until reset toggle
// [RQ20] protection off mode disables all protection
// [RQ21] decode protection straps, first low second high; straps are caught but not decoded, mode comes from CTRL override else latching
// [RQ22] output mode strap low selects bridge-tied load
// [RQ23] counter steps per pwm rise, zeroed on error
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pspc_top #(
  parameter int NUM_BRIDGES = 2,
  parameter int RECOVER_LEN = pspc_pkg::RECOVER_CYCLES
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   PIN_RESET_N,
  input  wire logic [NUM_BRIDGES-1:0] PWM_IN_POS,
  input  wire logic [NUM_BRIDGES-1:0] OC_HIGH_SIDE,
  input  wire logic [NUM_BRIDGES-1:0] OC_LOW_SIDE,
  input  wire logic                   GATE_SUPPLY_LOW,
  input  wire logic                   TEMP_ABOVE_WARN,
  input  wire logic                   TEMP_ABOVE_ERR,
  input  wire logic                   PROT_STRAP_A,
  input  wire logic                   PROT_STRAP_B,
  input  wire logic                   OUTPUT_MODE_STRAP,
  output logic [NUM_BRIDGES-1:0]      GATE_HIGH_ON,
  output logic [NUM_BRIDGES-1:0]      GATE_LOW_ON,
  output logic                        BRIDGE_HIZ,
  input  wire logic                   FAULT_SHUTDOWN_OUT_N_I,
  output logic                        FAULT_SHUTDOWN_OUT_N_O,
  output logic                        FAULT_SHUTDOWN_OUT_N_OE_N,
  input  wire logic                   TEMP_WARNING_OUT_N_I,
  output logic                        TEMP_WARNING_OUT_N_O,
  output logic                        TEMP_WARNING_OUT_N_OE_N,
  input  wire logic [3:0]             S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  input  wire logic [3:0]             S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY
);
  localparam int CW = $clog2(RECOVER_LEN) + 1;
  localparam logic [CW-1:0] HALF_LAST = CW'(RECOVER_LEN / 2 - 1);
  localparam logic [CW-1:0] FULL_LAST = CW'(RECOVER_LEN - 1);

  initial begin
    if (NUM_BRIDGES < 1 || RECOVER_LEN < 4 || RECOVER_LEN % 2 != 0) begin
      $error("pspc_top: bad parameters");
    end
  end

  // bus slave state
  logic        aw_hold_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_do;
  logic        wr_mapped;
  logic [3:0]  ctrl_reg;
  logic [2:0]  event_reg;
  logic [2:0]  event_clr;
  logic [31:0] status_word;
  // protection state
  logic                  rst_prev_reg;
  logic                  pwm_prev_reg;
  logic [1:0]            strap_reg;
  logic                  out_mode_reg;
  logic                  strap_valid_reg;
  logic                  latch_reg;
  logic                  latch_next;
  logic [CW-1:0]         count_reg;
  logic [CW-1:0]         count_next;
  pspc_pkg::rcv_state_type state_reg;
  pspc_pkg::rcv_state_type state_next;
  pspc_pkg::prot_mode_type mode;
  logic                  hiz_reg;
  logic                  hiz_next;
  logic                  oc_any;
  logic                  fault_now;
  logic                  rst_fall;
  logic                  pwm_rise;
  logic                  out_rsvd;

  // write channel: address and data taken in either order
  assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
  assign wr_do         = aw_hold_reg && w_hold_reg;
  assign wr_mapped     = (aw_addr_reg == pspc_pkg::OFS_CTRL)
                      || (aw_addr_reg == pspc_pkg::OFS_STATUS)
                      || (aw_addr_reg == pspc_pkg::OFS_ARCOUNT)
                      || (aw_addr_reg == pspc_pkg::OFS_EVENT);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= {S_AXI_AWADDR[3:2], 2'h0};
    end else if (wr_do) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end else if (wr_do) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pspc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? pspc_pkg::RESP_OKAY : pspc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= pspc_pkg::CTRL_RESET;
    end else if (wr_do && w_strb_reg[0] && aw_addr_reg == pspc_pkg::OFS_CTRL) begin
      ctrl_reg <= w_data_reg[3:0];
    end
  end

  // sticky fault causes; a new event wins over a clear
  assign event_clr = (wr_do && w_strb_reg[0] && aw_addr_reg == pspc_pkg::OFS_EVENT)
                   ? w_data_reg[2:0] : 3'h0;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      event_reg <= pspc_pkg::EV_RESET;
    end else begin
      event_reg <= (event_reg & ~event_clr)
                 | {TEMP_ABOVE_ERR, GATE_SUPPLY_LOW, oc_any};
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[pspc_pkg::ST_LATCH_BIT] = latch_reg;
    status_word[pspc_pkg::ST_HIZ_BIT]   = hiz_reg;
    status_word[pspc_pkg::ST_OC_BIT]    = oc_any;
    status_word[pspc_pkg::ST_UV_BIT]    = GATE_SUPPLY_LOW;
    status_word[pspc_pkg::ST_TERR_BIT]  = TEMP_ABOVE_ERR;
    status_word[pspc_pkg::ST_TWARN_BIT] = TEMP_ABOVE_WARN;
    status_word[pspc_pkg::ST_MODE_LSB +: 2] = mode;
    status_word[pspc_pkg::ST_RSVD_BIT]  = out_rsvd;
    status_word[pspc_pkg::ST_SDPIN_BIT] = FAULT_SHUTDOWN_OUT_N_I;
    status_word[pspc_pkg::ST_OTPIN_BIT] = TEMP_WARNING_OUT_N_I;
  end

  // read channel, answer one cycle after the address is taken
  assign S_AXI_ARREADY = !rvalid_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= pspc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= pspc_pkg::RESP_OKAY;
      if (S_AXI_ARADDR[3:2] == pspc_pkg::OFS_CTRL[3:2]) begin
        rdata_reg <= {28'h0, ctrl_reg};
      end else if (S_AXI_ARADDR[3:2] == pspc_pkg::OFS_STATUS[3:2]) begin
        rdata_reg <= status_word;
      end else if (S_AXI_ARADDR[3:2] == pspc_pkg::OFS_ARCOUNT[3:2]) begin
        rdata_reg <= 32'(count_reg);
      end else begin
        rdata_reg <= {29'h0, event_reg};
      end
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

  // straps caught once after reset release
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      strap_valid_reg <= 1'b0;
      strap_reg       <= pspc_pkg::STRAP_LATCH;
      out_mode_reg    <= pspc_pkg::OUT_MODE_BRIDGE_TIED;
    end else if (!strap_valid_reg) begin
      strap_valid_reg <= 1'b1;
      strap_reg       <= {PROT_STRAP_A, PROT_STRAP_B};
      out_mode_reg    <= OUTPUT_MODE_STRAP;
    end
  end

  // CTRL override selects the mode; no override or reserved code 3 falls back to latching, straps unused; see [RQ21]
  always_comb begin
    if (ctrl_reg[pspc_pkg::CTRL_OVR_BIT]
        && ctrl_reg[pspc_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
      mode = pspc_pkg::prot_mode_type'(ctrl_reg[pspc_pkg::CTRL_MODE_LSB +: 2]);
    end else begin
      mode = pspc_pkg::MODE_LATCH;
    end
  end

  assign out_rsvd = strap_valid_reg
                 && out_mode_reg != pspc_pkg::OUT_MODE_BRIDGE_TIED; // see [RQ22]

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rst_prev_reg <= 1'b0;
      pwm_prev_reg <= 1'b0;
    end else begin
      rst_prev_reg <= PIN_RESET_N;
      pwm_prev_reg <= PWM_IN_POS[0];
    end
  end

  assign rst_fall  = rst_prev_reg && !PIN_RESET_N;
  assign pwm_rise  = PWM_IN_POS[0] && !pwm_prev_reg; // see [RQ18]
  assign oc_any    = |(OC_HIGH_SIDE | OC_LOW_SIDE); // see [RQ14]
  assign fault_now = (oc_any || GATE_SUPPLY_LOW || TEMP_ABOVE_ERR) // see [RQ15] [RQ16]
                  && mode != pspc_pkg::MODE_OFF; // see [RQ20]

  always_comb begin
    latch_next = latch_reg;
    state_next = state_reg;
    count_next = count_reg;
    if (rst_fall) begin
      latch_next = 1'b0; // see [RQ12] [RQ11]
      state_next = pspc_pkg::RCV_IDLE;
      count_next = '0;
    end else if (state_reg != pspc_pkg::RCV_IDLE && pwm_rise) begin
      count_next = count_reg + CW'(1); // see [RQ23]
      if (count_reg == HALF_LAST) begin
        latch_next = 1'b0; // see [RQ17]
        state_next = pspc_pkg::RCV_WAIT;
      end
      if (count_reg == FULL_LAST) begin
        state_next = pspc_pkg::RCV_IDLE;
        count_next = '0;
      end
    end
    if (fault_now) begin
      latch_next = 1'b1; // see [RQ19]
      if (mode == pspc_pkg::MODE_AUTO) begin
        state_next = pspc_pkg::RCV_TRIP;
        count_next = '0; // see [RQ23]
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      latch_reg <= 1'b0;
      state_reg <= pspc_pkg::RCV_IDLE;
      count_reg <= '0;
    end else begin
      latch_reg <= latch_next;
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign hiz_next = !PIN_RESET_N // see [RQ1] [RQ13]
                 || latch_next // see [RQ10]
                 || state_next != pspc_pkg::RCV_IDLE // see [RQ17]
                 || ctrl_reg[pspc_pkg::CTRL_MUTE_BIT]
                 || out_rsvd || !strap_valid_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      hiz_reg      <= 1'b1;
      GATE_HIGH_ON <= '0;
      GATE_LOW_ON  <= '0;
    end else begin
      hiz_reg      <= hiz_next;
      GATE_HIGH_ON <= hiz_next ? '0 : PWM_IN_POS;
      GATE_LOW_ON  <= hiz_next ? '0 : ~PWM_IN_POS;
    end
  end

  assign BRIDGE_HIZ = hiz_reg;

  // open-drain pins: pull low when enabled, released otherwise
  assign FAULT_SHUTDOWN_OUT_N_O    = 1'b0;
  assign FAULT_SHUTDOWN_OUT_N_OE_N = !(PIN_RESET_N && latch_reg); // see [RQ6] [RQ7] [RQ9]
  assign TEMP_WARNING_OUT_N_O      = 1'b0;
  assign TEMP_WARNING_OUT_N_OE_N   = !(TEMP_ABOVE_WARN || TEMP_ABOVE_ERR); // see [RQ8] [RQ9]

  AST_RESET_MUTE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ1] [RQ13]
    !PIN_RESET_N |=> hiz_reg && GATE_HIGH_ON == '0 && GATE_LOW_ON == '0)
    else $error("switching while reset pin low");

  AST_SHDN_RELEASED: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ7]
    $fell(PIN_RESET_N) && !fault_now |-> FAULT_SHUTDOWN_OUT_N_OE_N ##1 !latch_reg)
    else $error("shutdown pin not released by reset");

  AST_SHDN_FAULT: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ6]
    fault_now && PIN_RESET_N ##1 PIN_RESET_N |-> !FAULT_SHUTDOWN_OUT_N_OE_N)
    else $error("shutdown pin not driven on fault");

  AST_ERR_HIZ: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ10]
    fault_now |=> hiz_reg && latch_reg)
    else $error("error did not force Hi-Z");

  AST_RCV_HALF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ17]
    state_reg == pspc_pkg::RCV_TRIP && count_reg == HALF_LAST && pwm_rise
    && !fault_now && !rst_fall |=> !latch_reg && hiz_reg
    && state_reg == pspc_pkg::RCV_WAIT)
    else $error("latch not cleared at half count");

  AST_RCV_RESUME: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ17]
    state_reg == pspc_pkg::RCV_WAIT && count_reg == FULL_LAST && pwm_rise
    && !fault_now && !rst_fall |=> state_reg == pspc_pkg::RCV_IDLE && count_reg == '0)
    else $error("no resume at full count");

  AST_RCV_RESTART: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ23]
    fault_now && mode == pspc_pkg::MODE_AUTO |=> count_reg == '0
    && state_reg == pspc_pkg::RCV_TRIP)
    else $error("counter not restarted by error");

  AST_LATCH_HOLD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ19]
    latch_reg && mode == pspc_pkg::MODE_LATCH && !rst_fall
    && state_reg == pspc_pkg::RCV_IDLE |=> latch_reg)
    else $error("latching shutdown released without reset");

  AST_FALL_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ12]
    rst_fall && !fault_now |=> !latch_reg)
    else $error("latch kept over reset falling edge");

  AST_OFF_MODE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ20]
    mode == pspc_pkg::MODE_OFF && !latch_reg |=> !latch_reg)
    else $error("protection acted in off mode");

  AST_OTW_PIN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // see [RQ8]
    TEMP_WARNING_OUT_N_OE_N == !(TEMP_ABOVE_WARN || TEMP_ABOVE_ERR))
    else $error("warning pin not driven when hot");
endmodule : pspc_top

// [tb/pspc_ctrl_model.sv]
`timescale 1ns/1ps
module pspc_ctrl_model #(
  parameter int PERIOD = 520,
  parameter int BOOT   = 200
) (
  input  wire logic  clk,
  input  wire logic  run,
  output logic       reset_n,
  output logic [1:0] pwm
);
  int   phase;
  int   boot_cnt;
  logic streaming;
  initial begin
    reset_n = 1'b0;
    pwm = 2'h0;
    phase = 0;
    boot_cnt = 0;
    streaming = 1'b0;
  end
  // streaming starts first; bootstrap wait shortened for simulation
  always @(posedge clk) begin
    if (run) begin
      streaming <= 1'b1;
      if (boot_cnt < BOOT) boot_cnt <= boot_cnt + 1;
      else reset_n <= 1'b1;
    end else begin
      reset_n <= 1'b0;
      boot_cnt <= 0;
      if (!reset_n) streaming <= 1'b0;
    end
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    // half duty; stopped lines fall to the pull-down
    pwm <= (streaming && phase < PERIOD / 2) ? 2'h3 : 2'h0;
  end
endmodule : pspc_ctrl_model

// [tb/pspc_top_tb.sv]
`timescale 1ns/1ps
module pspc_top_tb;
  logic        SYS_CLK, SYS_RST, PIN_RESET_N, GATE_SUPPLY_LOW, TEMP_ABOVE_WARN, TEMP_ABOVE_ERR;
  logic        PROT_STRAP_A, PROT_STRAP_B, OUTPUT_MODE_STRAP, BRIDGE_HIZ;
  logic [1:0]  PWM_IN_POS, OC_HIGH_SIDE, OC_LOW_SIDE, GATE_HIGH_ON, GATE_LOW_ON;
  logic        FAULT_SHUTDOWN_OUT_N_I, FAULT_SHUTDOWN_OUT_N_O, FAULT_SHUTDOWN_OUT_N_OE_N;
  logic        TEMP_WARNING_OUT_N_I, TEMP_WARNING_OUT_N_O, TEMP_WARNING_OUT_N_OE_N;
  logic [3:0]  S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic        run;
  logic [63:0] pq[$];
  logic [63:0] rq[$];
  logic [63:0] pe;
  logic [63:0] re;
  int          failures, checked, seed, b;

  // open-drain pins with internal pull-up
  assign FAULT_SHUTDOWN_OUT_N_I = FAULT_SHUTDOWN_OUT_N_OE_N ? 1'b1 : FAULT_SHUTDOWN_OUT_N_O;
  assign TEMP_WARNING_OUT_N_I = TEMP_WARNING_OUT_N_OE_N ? 1'b1 : TEMP_WARNING_OUT_N_O;

  pspc_top #(.NUM_BRIDGES(2), .RECOVER_LEN(8)) dut (.*);
  // boot wait spans two pwm periods so switching is seen before reset release
  pspc_ctrl_model #(.PERIOD(520), .BOOT(1100)) ctrl (
    .clk     (SYS_CLK),
    .run     (run),
    .reset_n (PIN_RESET_N),
    .pwm     (PWM_IN_POS)
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
    checked++;
    if ((seen & m) !== (exp & m)) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen & m, exp & m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : tick

  // pins: hiz, shutdown oe_n, warning oe_n, gates high, gates low
  task automatic ex(input logic [6:0] v, input logic [6:0] m);
    pq.push_back({25'h0, m, 25'h0, v});
    tick(1);
  endtask : ex

  task automatic mid_high();
    @(posedge PWM_IN_POS[0]);
    tick(10);
  endtask : mid_high

  task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m);
    rq.push_back({m, v});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    fork
      begin do @(posedge SYS_CLK); while (!S_AXI_AWREADY); S_AXI_AWVALID <= 1'b0; end
      begin do @(posedge SYS_CLK); while (!S_AXI_WREADY); S_AXI_WVALID <= 1'b0; end
    join
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wr

  task automatic fault(input int k, input logic v, input int idx);
    case (k)
      0: OC_HIGH_SIDE[idx] <= v;
      1: OC_LOW_SIDE[idx] <= v;
      2: GATE_SUPPLY_LOW <= v;
      default: TEMP_ABOVE_ERR <= v;
    endcase
  endtask : fault

  task automatic toggle();
    run <= 1'b0;
    tick(5);
    ex(7'h70, 7'h7F);
    run <= 1'b1;
    while (!PIN_RESET_N) @(posedge SYS_CLK);
    mid_high();
    ex(7'h3C, 7'h7F);
  endtask : toggle

  always @(negedge SYS_CLK) begin
    if (pq.size() > 0) begin
      pe = pq.pop_front();
      chk({25'h0, BRIDGE_HIZ, FAULT_SHUTDOWN_OUT_N_OE_N, TEMP_WARNING_OUT_N_OE_N,
           GATE_HIGH_ON, GATE_LOW_ON}, pe[31:0], pe[63:32]);
    end
  end

  always @(posedge SYS_CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY && rq.size() > 0) begin
      re = rq.pop_front();
      chk(S_AXI_RDATA, re[31:0], re[63:32]);
    end
    if (S_AXI_BVALID && S_AXI_BREADY) chk({30'h0, S_AXI_BRESP}, 32'h0, 32'h3);
  end

  initial begin
    tick(80000);
    failures++;
    end_of_test();
  end

  initial begin
    seed = 13828;
    run = 1'b0;
    SYS_RST = 1'b1;
    {GATE_SUPPLY_LOW, TEMP_ABOVE_WARN, TEMP_ABOVE_ERR, PROT_STRAP_A, OUTPUT_MODE_STRAP} = '0;
    PROT_STRAP_B = 1'b1;
    {OC_HIGH_SIDE, OC_LOW_SIDE} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    tick(10);
    SYS_RST <= 1'b0;
    tick(1);
    rd(pspc_pkg::OFS_CTRL, {28'h0, pspc_pkg::CTRL_RESET}, 32'hF);
    rd(pspc_pkg::OFS_EVENT, 32'h0, 32'h7);
    ex(7'h70, 7'h7F);
    run <= 1'b1;
    while (!PIN_RESET_N) @(posedge SYS_CLK);
    mid_high();
    ex(7'h3C, 7'h7F);
    $display("test start done");
    TEMP_ABOVE_WARN <= 1'b1;
    tick(3);
    ex(7'h20, 7'h70);
    TEMP_ABOVE_WARN <= 1'b0;
    tick(3);
    ex(7'h30, 7'h70);
    $display("test warning done");
    for (int k = 0; k < 4; k++) begin
      b = $random(seed) & 1;
      fault(k, 1'b1, b);
      tick(3);
      ex(k == 3 ? 7'h40 : 7'h50, 7'h7F);
      fault(k, 1'b0, b);
      tick(1200);
      ex(7'h50, 7'h7F);
      rd(pspc_pkg::OFS_STATUS, 32'h43, 32'hC3);
      rd(pspc_pkg::OFS_EVENT, 32'h1 << (k < 2 ? 0 : k - 1), 32'h7);
      wr(pspc_pkg::OFS_EVENT, 32'h7);
      rd(pspc_pkg::OFS_EVENT, 32'h0, 32'h7);
      toggle();
      $display("test fault %0d done", k);
    end
    wr(pspc_pkg::OFS_CTRL, 32'h1);
    @(negedge PWM_IN_POS[0]);
    tick(1);
    fault(0, 1'b1, 0);
    tick(3);
    fault(0, 1'b0, 0);
    for (int i = 1; i < 10; i++) begin
      mid_high();
      if (i == 3) ex(7'h50, 7'h7F);
      if (i == 4 || i == 6) ex(7'h70, 7'h7F);
      if (i == 9) ex(7'h3C, 7'h7F);
    end
    $display("test autorecovery done");
    wr(pspc_pkg::OFS_CTRL, 32'h5);
    fault(2, 1'b1, 0);
    mid_high();
    ex(7'h3C, 7'h7F);
    rd(pspc_pkg::OFS_STATUS, 32'h80, 32'hC0);
    fault(2, 1'b0, 0);
    wr(pspc_pkg::OFS_CTRL, 32'h0);
    $display("test protection off done");
    OUTPUT_MODE_STRAP <= 1'b1;
    SYS_RST <= 1'b1;
    tick(2);
    SYS_RST <= 1'b0;
    tick(600);
    ex(7'h70, 7'h7F);
    $display("test output strap done");
    end_of_test();
  end
endmodule : pspc_top_tb
